/* File: rtl/iabd_pkg.sv */
package iabd_pkg;

	// ====================================================================
	// Register offsets on the plain register port
	localparam logic [2:0] OFS_CTRL   = 3'h0;
	localparam logic [2:0] OFS_STAT   = 3'h1;
	localparam logic [2:0] OFS_DIV    = 3'h2;
	localparam logic [2:0] OFS_BUF    = 3'h3;
	localparam logic [2:0] OFS_MSK    = 3'h4;
	localparam logic [2:0] OFS_THR    = 3'h5;

	// ====================================================================
	// Field positions
	localparam int unsigned CTRL_MODE_LSB = 0;
	localparam int unsigned CTRL_EN_BIT   = 4;
	localparam int unsigned CTRL_PINS_BIT = 5;
	localparam int unsigned ST_MATCH_BIT  = 0;
	localparam int unsigned ST_HIGH_BIT   = 1;
	localparam int unsigned ST_FULL_BIT   = 2;
	localparam int unsigned ST_SCL_BIT    = 3;

	// ====================================================================
	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DIV_RST  = 8'h00;
	localparam logic [7:0] MSK_RST  = 8'hff;
	localparam logic [7:0] THR_RST  = 8'h00;

	// ====================================================================
	// Port mode codes and fixed bus patterns
	localparam logic [3:0] MODE_MASTER = 4'h8;
	localparam logic [3:0] MODE_SLV7   = 4'h6;
	localparam logic [3:0] MODE_SLV10  = 4'h7;
	localparam logic [3:0] MODE_SLV7S  = 4'he;
	localparam logic [3:0] MODE_SLV10S = 4'hf;
	localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
	localparam logic [3:0] LAST_BIT    = 4'h7;
	localparam logic [3:0] ACK_BIT     = 4'h8;
	localparam int unsigned SCL_MULT   = 4;

	// ====================================================================
	// Carriers and states
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       we;
		logic       re;
	} iabd_bus_req_t;

	typedef enum logic [3:0] {
		SL_IDLE   = 4'b0001,
		SL_FIRST  = 4'b0010,
		SL_SECOND = 4'b0100,
		SL_DATA   = 4'b1000
	} iabd_slv_state_t;

endpackage : iabd_pkg

/* File: rtl/iabd_top.sv */
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module iabd_top #(
	parameter int unsigned PINS = 2
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire iabd_pkg::iabd_bus_req_t bus_req,
	output logic [7:0]                 rdata_q,
	input  wire logic                  scl_i,
	output logic                       scl_o_q,
	output logic                       scl_oe_q,
	input  wire logic                  sda_i,
	output logic                       sda_o_q,
	output logic                       sda_oe_q,
	output logic [PINS-1:0]            input_threshold_select_q
);

	// ====================================================================
	// Register file state
	logic [7:0]      ctrl_q, ctrl_d;
	logic [7:0]      div_q, div_d;
	logic [7:0]      msk_q, msk_d;
	logic [7:0]      thr_q, thr_d;
	logic [7:0]      buf_q, buf_d;
	logic            match_q, match_d;
	logic            high_q, high_d;
	logic            full_q, full_d;
	logic [7:0]      rdata_d;
	logic [PINS-1:0] thr_out_d;

	// ====================================================================
	// Pin input synchronisers
	logic [2:0] scl_s_q, sda_s_q;
	logic       scl_f_q, sda_f_q, scl_f_d, sda_f_d;

	// ====================================================================
	// Master clock generator and slave receiver state
	logic [8:0]                 cnt_q, cnt_d;
	logic                       scl_oe_d;
	iabd_pkg::iabd_slv_state_t  st_q, st_d;
	logic [3:0]                 bit_q, bit_d;
	logic [7:0]                 shf_q, shf_d;

	logic [3:0] mode;
	logic       enabled, is_master, ten_bit, slave_on;
	logic       scl_rise, start_cond, stop_cond;
	logic [7:0] byte_in;
	logic       hi_hit, lo_hit, s7_hit, byte_done, rx_store;
	logic [8:0] half_reload;

	assign mode      = ctrl_q[iabd_pkg::CTRL_MODE_LSB +: 4];
	assign enabled   = ctrl_q[iabd_pkg::CTRL_EN_BIT];
	assign is_master = enabled && (mode == iabd_pkg::MODE_MASTER);
	assign ten_bit   = (mode == iabd_pkg::MODE_SLV10) || (mode == iabd_pkg::MODE_SLV10S);
	assign slave_on  = enabled && (ten_bit || mode == iabd_pkg::MODE_SLV7 || mode == iabd_pkg::MODE_SLV7S);

	// Half period is 2*(divider+1) cycles, so a full period is 4*(divider+1)
	assign half_reload = {div_q, 1'b1};

	// Edges are judged on the filtered levels only
	assign scl_rise   = scl_f_d && !scl_f_q;
	assign start_cond = scl_f_q && sda_f_q && !sda_f_d;
	assign stop_cond  = scl_f_q && !sda_f_q && sda_f_d;
	assign byte_in    = {shf_q[6:0], sda_f_q};

	// Address comparison, masked bit by bit
	assign hi_hit = (byte_in[7:3] == iabd_pkg::TEN_BIT_HDR)
		&& (((byte_in[2:1] ^ div_q[2:1]) & msk_q[2:1]) == 2'h0);
	assign lo_hit = ((byte_in ^ div_q) & msk_q) == 8'h00;
	assign s7_hit = ((byte_in[7:1] ^ div_q[7:1]) & msk_q[7:1]) == 7'h00;
	assign byte_done = scl_rise && (bit_q == iabd_pkg::LAST_BIT);

	// ====================================================================
	// Synchroniser: first stage feeds only the second; a change counts once
	// the second and third stages agree, which also rejects one-cycle glitches
	always_comb begin
		scl_f_d = (scl_s_q[1] == scl_s_q[2]) ? scl_s_q[2] : scl_f_q;
		sda_f_d = (sda_s_q[1] == sda_s_q[2]) ? sda_s_q[2] : sda_f_q;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			scl_f_q <= 1'b1;
			sda_f_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			scl_f_q <= scl_f_d;
			sda_f_q <= sda_f_d;
		end
	end

	// ====================================================================
	// Master clock: open-drain, so low phase drives and high phase releases.
	// Divider values below three are not guarded; the bus still sees a clock.
	always_comb begin
		cnt_d    = cnt_q;
		scl_oe_d = scl_oe_q;
		if (!is_master) begin
			cnt_d    = half_reload;
			scl_oe_d = 1'b0;
		end else if (cnt_q == 9'h000) begin
			cnt_d    = half_reload;
			scl_oe_d = !scl_oe_q;
		end else begin
			cnt_d = cnt_q - 9'h001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_q    <= 9'h000;
			scl_oe_q <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			scl_oe_q <= scl_oe_d;
		end
	end

	// ====================================================================
	// Slave address receiver: shifts on each rising clock edge, compares on
	// the eighth bit and skips the ninth (acknowledge) clock
	always_comb begin
		st_d     = st_q;
		bit_d    = bit_q;
		shf_d    = shf_q;
		rx_store = 1'b0;
		if (!slave_on || stop_cond) begin
			st_d = iabd_pkg::SL_IDLE;
		end else if (start_cond) begin
			st_d  = iabd_pkg::SL_FIRST;
			bit_d = 4'h0;
		end else if (scl_rise && st_q != iabd_pkg::SL_IDLE) begin
			bit_d = (bit_q == iabd_pkg::ACK_BIT) ? 4'h0 : bit_q + 4'h1;
			if (bit_q <= iabd_pkg::LAST_BIT)
				shf_d = byte_in;
		end
		if (slave_on && !start_cond && !stop_cond && byte_done) begin
			case (st_q)
				iabd_pkg::SL_FIRST: begin
					if (ten_bit && hi_hit) begin
						st_d = iabd_pkg::SL_SECOND;
					end else if (!ten_bit && s7_hit) begin
						rx_store = 1'b1;
						st_d     = iabd_pkg::SL_DATA;
					end else begin
						st_d = iabd_pkg::SL_IDLE;
					end
				end
				iabd_pkg::SL_SECOND: begin
					if (lo_hit) begin
						rx_store = 1'b1;
						st_d     = iabd_pkg::SL_DATA;
					end else begin
						st_d = iabd_pkg::SL_IDLE;
					end
				end
				iabd_pkg::SL_DATA: rx_store = 1'b1;
				default: st_d = iabd_pkg::SL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q  <= iabd_pkg::SL_IDLE;
			bit_q <= 4'h0;
			shf_q <= 8'h00;
		end else begin
			st_q  <= st_d;
			bit_q <= bit_d;
			shf_q <= shf_d;
		end
	end

	// ====================================================================
	// Register writes, status flags and read data. Match, high and full clear by
	// writing one; a hardware set in the same cycle wins over the clear.
	always_comb begin
		ctrl_d    = ctrl_q;
		div_d     = div_q;
		msk_d     = msk_q;
		thr_d     = thr_q;
		buf_d     = buf_q;
		full_d    = full_q;
		match_d   = match_q; // Flags have one next-value source; the sets below follow the state
		high_d    = high_q;
		rdata_d   = 8'h00;
		if (bus_req.we) begin
			case (bus_req.addr)
				iabd_pkg::OFS_CTRL: ctrl_d = bus_req.wdata;
				iabd_pkg::OFS_DIV:  div_d  = bus_req.wdata;
				iabd_pkg::OFS_MSK:  msk_d  = bus_req.wdata;
				iabd_pkg::OFS_THR:  thr_d  = bus_req.wdata;
				iabd_pkg::OFS_BUF:  buf_d  = bus_req.wdata;
				iabd_pkg::OFS_STAT: begin
					if (bus_req.wdata[iabd_pkg::ST_MATCH_BIT])
						match_d = 1'b0;
					if (bus_req.wdata[iabd_pkg::ST_HIGH_BIT])
						high_d = 1'b0;
					if (bus_req.wdata[iabd_pkg::ST_FULL_BIT])
						full_d = 1'b0;
				end
				default: ;
			endcase
		end
		if (bus_req.re && bus_req.addr == iabd_pkg::OFS_BUF)
			full_d = 1'b0;
		if (rx_store) begin
			buf_d  = byte_in;
			full_d = 1'b1;
		end
		if (st_d == iabd_pkg::SL_DATA && st_q != iabd_pkg::SL_DATA)
			match_d = 1'b1;
		if (st_d == iabd_pkg::SL_SECOND && st_q != iabd_pkg::SL_SECOND)
			high_d = 1'b1;
		if (bus_req.re) begin
			case (bus_req.addr)
				iabd_pkg::OFS_CTRL: rdata_d = ctrl_q;
				iabd_pkg::OFS_STAT: rdata_d = {4'h0, scl_oe_q, full_q, high_q, match_q};
				iabd_pkg::OFS_DIV:  rdata_d = div_q;
				iabd_pkg::OFS_BUF:  rdata_d = buf_q;
				iabd_pkg::OFS_MSK:  rdata_d = msk_q;
				iabd_pkg::OFS_THR:  rdata_d = thr_q;
				default:            rdata_d = 8'h00;
			endcase
		end
		// Dedicated bus pins always use the bus input levels
		thr_out_d = ctrl_q[iabd_pkg::CTRL_PINS_BIT] ? '0 : thr_q[PINS-1:0];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q  <= iabd_pkg::CTRL_RST;
			div_q   <= iabd_pkg::DIV_RST;
			msk_q   <= iabd_pkg::MSK_RST;
			thr_q   <= iabd_pkg::THR_RST;
			match_q <= 1'b0;
			high_q  <= 1'b0;
			full_q  <= 1'b0;
			rdata_q <= 8'h00;
			input_threshold_select_q <= '0;
			scl_o_q  <= 1'b0;
			sda_o_q  <= 1'b0;
			sda_oe_q <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			div_q   <= div_d;
			msk_q   <= msk_d;
			thr_q   <= thr_d;
			match_q <= match_d;
			high_q  <= high_d;
			full_q  <= full_d;
			rdata_q <= rdata_d;
			input_threshold_select_q <= thr_out_d;
			scl_o_q  <= 1'b0;
			sda_o_q  <= 1'b0;
			sda_oe_q <= 1'b0;
		end
	end

	// Buffer content survives reset and starts unknown
	always_ff @(posedge clk) begin
		buf_q <= buf_d;
	end

	// ====================================================================
	// Checks
	logic [8:0] since_q;
	// Cycles since the last clock toggle; restarts on the toggle edge itself
	always_ff @(posedge clk) begin
		if (!rst_n || !is_master || scl_oe_d != scl_oe_q)
			since_q <= 9'h000;
		else
			since_q <= since_q + 9'h001;
	end

	property p_half_period;
		@(posedge clk) disable iff (!rst_n)
		is_master && cnt_q == 9'h000 |=> scl_oe_q != $past(scl_oe_q) && cnt_q == $past(half_reload);
	endproperty
	a_half_period: assert property (p_half_period) else $error("no toggle or reload at count end");

	property p_toggle_spacing;
		@(posedge clk) disable iff (!rst_n)
		(is_master && $stable(div_q) && $stable(is_master) && scl_oe_d != scl_oe_q && since_q != 9'h000)
			|-> since_q == half_reload;
	endproperty
	a_toggle_spacing: assert property (p_toggle_spacing) else $error("half period not 2*(div+1)");

	property p_hdr_fixed;
		@(posedge clk) disable iff (!rst_n)
		(st_q == iabd_pkg::SL_FIRST && byte_done && ten_bit && slave_on && !stop_cond && !start_cond
			&& byte_in[7:3] != iabd_pkg::TEN_BIT_HDR) |=> st_q == iabd_pkg::SL_IDLE;
	endproperty
	a_hdr_fixed: assert property (p_hdr_fixed) else $error("bad ten-bit header accepted");

	property p_hi_bits;
		@(posedge clk) disable iff (!rst_n)
		(st_q == iabd_pkg::SL_FIRST && byte_done && ten_bit && slave_on && !stop_cond && !start_cond
			&& byte_in[7:3] == iabd_pkg::TEN_BIT_HDR && ((byte_in[2:1] ^ div_q[2:1]) & msk_q[2:1]) == 2'h0)
			|=> st_q == iabd_pkg::SL_SECOND && high_q;
	endproperty
	a_hi_bits: assert property (p_hi_bits) else $error("upper byte match missed");

	property p_lo_byte;
		@(posedge clk) disable iff (!rst_n)
		(st_q == iabd_pkg::SL_SECOND && byte_done && slave_on && !stop_cond && !start_cond)
			|=> (st_q == iabd_pkg::SL_DATA) == $past(((byte_in ^ div_q) & msk_q) == 8'h00);
	endproperty
	a_lo_byte: assert property (p_lo_byte) else $error("lower byte compare wrong");

	property p_seven;
		@(posedge clk) disable iff (!rst_n)
		(st_q == iabd_pkg::SL_FIRST && byte_done && !ten_bit && slave_on && !stop_cond && !start_cond)
			|=> (match_q && buf_q == $past(byte_in)) == $past(s7_hit) || $past(match_q);
	endproperty
	a_seven: assert property (p_seven) else $error("seven-bit compare wrong");

	property p_thr;
		@(posedge clk) disable iff (!rst_n)
		ctrl_q[iabd_pkg::CTRL_PINS_BIT] && $past(ctrl_q[iabd_pkg::CTRL_PINS_BIT]) && $past(rst_n)
			|-> input_threshold_select_q == '0;
	endproperty
	a_thr: assert property (p_thr) else $error("threshold not ignored");

	property p_div_reset;
		@(posedge clk) !rst_n |=> div_q == 8'h00 && rdata_q == 8'h00;
	endproperty
	a_div_reset: assert property (p_div_reset) else $error("divider not zero after reset");

	property p_read_one;
		@(posedge clk) disable iff (!rst_n)
		!bus_req.re |=> rdata_q == 8'h00;
	endproperty
	a_read_one: assert property (p_read_one) else $error("read data outside its cycle");

	c_master: cover property (@(posedge clk) disable iff (!rst_n) is_master && $rose(scl_oe_q));
	c_ten_match: cover property (@(posedge clk) disable iff (!rst_n) ten_bit && $rose(match_q));
	c_seven_match: cover property (@(posedge clk) disable iff (!rst_n) !ten_bit && $rose(match_q));

endmodule : iabd_top

`default_nettype wire

/* File: testbench/iabd_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// Other master on the two-wire bus, addressing the block as a slave
module iabd_bus_model #(
	parameter int HALF = 20
) (
	input  wire logic clk,
	input  wire logic scl_line,
	input  wire logic sda_line,
	output var  logic scl_pull,
	output var  logic sda_pull
);
	// Open drain: a released line floats to the pull-up level
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	task automatic hold();
		repeat (HALF) @(posedge clk);
	endtask : hold

	// Start: data falls while the clock line is high
	task automatic start();
		while (!(scl_line && sda_line))
			@(posedge clk);
		sda_pull <= 1'b1;
		hold();
		scl_pull <= 1'b1;
		hold();
	endtask : start

	// MSB first; the ninth clock leaves data released for the acknowledge
	task automatic send_byte(input logic [7:0] b);
		for (int i = 8; i >= 0; i--) begin
			sda_pull <= (i > 0) ? ~b[i-1] : 1'b0;
			hold();
			scl_pull <= 1'b0;
			hold();
			scl_pull <= 1'b1;
			// Data moving with the falling clock would look like a start or stop
			repeat (4) @(posedge clk);
		end
	endtask : send_byte

	// Stop: data rises while the clock line is high
	task automatic stop();
		sda_pull <= 1'b1;
		hold();
		scl_pull <= 1'b0;
		hold();
		sda_pull <= 1'b0;
		hold();
	endtask : stop
endmodule : iabd_bus_model

`default_nettype wire

/* File: testbench/tb_iabd_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_iabd_top;
	logic                    clk;
	logic                    rst_n;
	iabd_pkg::iabd_bus_req_t bus_req;
	logic [7:0]              rdata_q;
	logic                    scl_oe_q;
	logic                    scl_o_q;
	logic                    sda_o_q;
	logic                    sda_oe_q;
	logic                    scl_pull;
	logic                    sda_pull;
	logic [1:0]              thr_q;
	wire logic               scl_line;
	wire logic               sda_line;
	int                      num_errors;
	int                      comparisons;

	// Wired-AND bus with pull-ups
	assign scl_line = ~(scl_oe_q | scl_pull);
	assign sda_line = ~(sda_oe_q | sda_pull);

	iabd_top #(.PINS(2)) DUT (.clk(clk), .rst_n(rst_n), .bus_req(bus_req), .rdata_q(rdata_q),
		.scl_i(scl_line), .scl_o_q(scl_o_q), .scl_oe_q(scl_oe_q), .sda_i(sda_line), .sda_o_q(sda_o_q),
		.sda_oe_q(sda_oe_q), .input_threshold_select_q(thr_q));

	iabd_bus_model #(.HALF(20)) peer (.clk(clk), .scl_line(scl_line), .sda_line(sda_line),
		.scl_pull(scl_pull), .sda_pull(sda_pull));

	// ====================================================================
	// Clock, comparison and register bus tasks
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
		@(posedge clk);
		bus_req <= '0;
	endtask : wr

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
		@(posedge clk);
		bus_req <= '0;
		#1 d = rdata_q;
	endtask : rd

	task automatic chk_rd(input string name, input logic [2:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check(name, d, exp);
	endtask : chk_rd

	task automatic chk_flag(input string name, input int b, input logic exp);
		logic [7:0] d;
		rd(iabd_pkg::OFS_STAT, d);
		check(name, {7'h00, d[b]}, {7'h00, exp});
	endtask : chk_flag

	task automatic frame(input logic [7:0] b);
		@(posedge clk);
		peer.start();
		peer.send_byte(b);
		peer.stop();
	endtask : frame

	task automatic run_len(input logic lvl, output int n);
		n = 0;
		while (scl_oe_q === lvl && n < 1000) begin
			@(posedge clk);
			#1 n++;
		end
	endtask : run_len

	// ====================================================================
	// Scenarios
	task automatic t_reset();
		chk_rd("div_rst", iabd_pkg::OFS_DIV, 8'h00);
		chk_rd("msk_rst", iabd_pkg::OFS_MSK, 8'hff);
		wr(3'h6, 8'h5a);
		chk_rd("unmapped", 3'h6, 8'h00);
		wr(iabd_pkg::OFS_BUF, 8'h3c);
		wr(iabd_pkg::OFS_DIV, 8'h77);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk_rd("buf_kept", iabd_pkg::OFS_BUF, 8'h3c);
		chk_rd("div_zero", iabd_pkg::OFS_DIV, 8'h00);
	endtask : t_reset

	// Divider kept at 3 or more while in bus mode
	task automatic t_master();
		int h;
		int l;
		wr(iabd_pkg::OFS_DIV, 8'h03);
		wr(iabd_pkg::OFS_CTRL, 8'h18);
		run_len(1'b0, l);
		run_len(1'b1, h);
		run_len(1'b0, l);
		check("scl_high", 8'(h), 8'h08);
		check("scl_low", 8'(l), 8'h08);
		check("pin_out", {5'h00, scl_o_q, sda_o_q, sda_oe_q}, 8'h00);
		wr(iabd_pkg::OFS_CTRL, 8'h00);
		repeat (12) @(posedge clk);
		#1 check("scl_idle", {7'h00, scl_oe_q}, 8'h00);
	endtask : t_master

	task automatic t_slv7();
		wr(iabd_pkg::OFS_CTRL, 8'h16);
		wr(iabd_pkg::OFS_DIV, 8'ha5);
		frame(8'ha4);
		chk_flag("m7_hit", iabd_pkg::ST_MATCH_BIT, 1'b1);
		wr(iabd_pkg::OFS_STAT, 8'h07);
		frame(8'ha6);
		chk_flag("m7_miss", iabd_pkg::ST_MATCH_BIT, 1'b0);
		wr(iabd_pkg::OFS_MSK, 8'hfd);
		frame(8'ha6);
		chk_flag("m7_mask", iabd_pkg::ST_MATCH_BIT, 1'b1);
		chk_rd("m7_buf", iabd_pkg::OFS_BUF, 8'ha6);
		wr(iabd_pkg::OFS_MSK, 8'hff);
	endtask : t_slv7

	task automatic t_slv10();
		wr(iabd_pkg::OFS_CTRL, 8'h17);
		wr(iabd_pkg::OFS_DIV, 8'h03);
		wr(iabd_pkg::OFS_STAT, 8'h07);
		@(posedge clk);
		peer.start();
		peer.send_byte(8'hf2);
		chk_flag("hi_hit", iabd_pkg::ST_HIGH_BIT, 1'b1);
		wr(iabd_pkg::OFS_DIV, 8'h5a);
		peer.send_byte(8'h5a);
		peer.stop();
		chk_flag("lo_hit", iabd_pkg::ST_MATCH_BIT, 1'b1);
		chk_flag("full", iabd_pkg::ST_FULL_BIT, 1'b1);
		chk_rd("m10_buf", iabd_pkg::OFS_BUF, 8'h5a);
		wr(iabd_pkg::OFS_DIV, 8'h03);
		wr(iabd_pkg::OFS_STAT, 8'h07);
		frame(8'he2);
		chk_flag("hi_hdr", iabd_pkg::ST_HIGH_BIT, 1'b0);
		frame(8'hf4);
		chk_flag("hi_bits", iabd_pkg::ST_HIGH_BIT, 1'b0);
	endtask : t_slv10

	task automatic t_thr();
		wr(iabd_pkg::OFS_THR, 8'h03);
		wr(iabd_pkg::OFS_CTRL, 8'h00);
		repeat (2) @(posedge clk);
		#1 check("thr_pass", {6'h00, thr_q}, 8'h03);
		wr(iabd_pkg::OFS_CTRL, 8'h20);
		repeat (2) @(posedge clk);
		#1 check("thr_off", {6'h00, thr_q}, 8'h00);
	endtask : t_thr

	task automatic tally_and_finish();
		$display("Checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	// Whole run is some three and a half thousand cycles; the limit leaves more than fivefold margin
	initial begin
		#(40 * 20000);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		num_errors = 0;
		comparisons = 0;
		rst_n = 1'b0;
		bus_req = '0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_master();
		t_slv7();
		t_slv10();
		t_thr();
		tally_and_finish();
	end
endmodule : tb_iabd_top

`default_nettype wire
